/* File: common/ssap_map.svh */
// Constants of the stereo serial audio port: rates, widths, reset values
`ifndef SSAP_MAP_SVH
`define SSAP_MAP_SVH

// ----------------------------------------------------------------------
// Clock and rates
// ----------------------------------------------------------------------
`define SSAP_CLK_HZ 64'd25000000
`define SSAP_BCLK_441_HZ 64'd1411200
`define SSAP_BCLK_48_HZ 64'd1536000
`define SSAP_SLAVE_MAX_HZ 64'd3072000
`define SSAP_ACC_W 24

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SSAP_WORD_BITS 16
`define SSAP_FRAME_BITS 32
`define SSAP_BIT_LAST 4'hF

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SSAP_SCK_RST 1'b0
`define SSAP_WS_RST 1'b0
`define SSAP_SDO_RST 1'b0

`endif

/* File: common/ssap_pkg.sv */
// Types of the stereo serial audio port
package ssap_pkg;

  typedef logic [15:0] ssap_word_t;

  typedef enum logic [1:0] {
    ssap_role_off = 2'b00,
    ssap_role_master = 2'b01,
    ssap_role_slave = 2'b10
  } ssap_role_e;

endpackage : ssap_pkg

/* File: rtl/ssap_sync.sv */
// Two-flop synchroniser for one pin input
`timescale 1ns/1ns
module ssap_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pin in, synchronised out
  input wire logic pin_in,
  output logic pin_sync
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;

endmodule : ssap_sync

/* File: rtl/ssap_top.sv */
// Stereo serial audio port: master or slave, 16-bit words, 32-bit frames
`timescale 1ns/1ns
`include "ssap_map.svh"
module ssap_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Configuration
  input wire logic cfg_enable,
  input wire logic cfg_master,
  input wire logic cfg_rate_48k,
  input wire logic cfg_source,
  input wire logic pcm_claim,
  output logic audio_grant,
  // Sample side
  input wire ssap_pkg::ssap_word_t tx_left,
  input wire ssap_pkg::ssap_word_t tx_right,
  output logic tx_take,
  output ssap_pkg::ssap_word_t rx_left,
  output ssap_pkg::ssap_word_t rx_right,
  output logic rx_valid,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe,
  output logic sdo,
  input wire logic sdi
);

  // ----------------------------------------------------------------------
  // Divider increments
  // ----------------------------------------------------------------------
  // Phase accumulator overflows twice per bit period
  localparam logic [`SSAP_ACC_W-1:0] INC_441 = `SSAP_ACC_W'(
    (64'd2 * `SSAP_BCLK_441_HZ * (64'd1 << `SSAP_ACC_W)) / `SSAP_CLK_HZ);
  localparam logic [`SSAP_ACC_W-1:0] INC_48 = `SSAP_ACC_W'(
    (64'd2 * `SSAP_BCLK_48_HZ * (64'd1 << `SSAP_ACC_W)) / `SSAP_CLK_HZ);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ssap_pkg::ssap_role_e role_r;
  ssap_pkg::ssap_role_e role_nxt;
  logic grant_r;
  logic src_r;
  logic sck_oe_r;
  logic ws_oe_r;
  logic [`SSAP_ACC_W-1:0] acc_r;
  logic [`SSAP_ACC_W:0] acc_sum;
  logic carry;
  logic [3:0] half_cnt_r;
  logic sck_r;
  logic ws_r;
  logic [3:0] bit_cnt_r;
  logic sck_s;
  logic ws_s;
  logic sdi_s;
  logic sck_d_r;
  logic is_master;
  logic is_slave;
  logic fall_ev;
  logic rise_ev;
  logic ws_line;
  logic ws_rise_r;
  logic ws_fall_r;
  logic word_start;
  ssap_pkg::ssap_word_t right_hold_r;
  ssap_pkg::ssap_word_t load_word;
  ssap_pkg::ssap_word_t tx_sh_r;
  logic sdo_r;
  logic tx_take_r;
  ssap_pkg::ssap_word_t rx_sh_r;
  ssap_pkg::ssap_word_t rx_sh_nxt;
  ssap_pkg::ssap_word_t rx_left_hold_r;
  ssap_pkg::ssap_word_t rx_left_r;
  ssap_pkg::ssap_word_t rx_right_r;
  logic rx_valid_r;

  // ----------------------------------------------------------------------
  // Ownership and role
  // ----------------------------------------------------------------------
  always_comb begin
    if (!cfg_enable || pcm_claim) begin
      role_nxt = ssap_pkg::ssap_role_off;
    end else if (cfg_master) begin
      role_nxt = ssap_pkg::ssap_role_master;
    end else begin
      role_nxt = ssap_pkg::ssap_role_slave;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      role_r <= ssap_pkg::ssap_role_off;
      grant_r <= 1'b0;
      src_r <= 1'b0;
      sck_oe_r <= 1'b0;
      ws_oe_r <= 1'b0;
    end else begin
      role_r <= role_nxt;
      grant_r <= (role_nxt != ssap_pkg::ssap_role_off);
      src_r <= cfg_source;
      // Pins turn only while we own the hardware in master role
      sck_oe_r <= (role_nxt == ssap_pkg::ssap_role_master);
      ws_oe_r <= (role_nxt == ssap_pkg::ssap_role_master);
    end
  end

  assign is_master = (role_r == ssap_pkg::ssap_role_master);
  assign is_slave = (role_r == ssap_pkg::ssap_role_slave);

  // ----------------------------------------------------------------------
  // Master bit clock and word select
  // ----------------------------------------------------------------------
  assign acc_sum = {1'b0, acc_r} + {1'b0, (cfg_rate_48k ? INC_48 : INC_441)};
  assign carry = acc_sum[`SSAP_ACC_W];

  // Fractional divider: jitter of one system cycle, average rate slightly below nominal as the increment is truncated
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_r <= '0;
      sck_r <= `SSAP_SCK_RST;
    end else if (!is_master) begin
      acc_r <= '0;
      sck_r <= `SSAP_SCK_RST;
    end else begin
      acc_r <= acc_sum[`SSAP_ACC_W-1:0];
      if (carry) begin
        sck_r <= ~sck_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= 4'h0;
      ws_r <= `SSAP_WS_RST;
    end else if (!is_master) begin
      bit_cnt_r <= 4'h0;
      ws_r <= `SSAP_WS_RST;
    end else if (carry && sck_r) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == `SSAP_BIT_LAST) begin
        ws_r <= ~ws_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Slave pin sampling
  // ----------------------------------------------------------------------
  ssap_sync u_sync_sck (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in(sck_i),
    .pin_sync(sck_s)
  );

  ssap_sync u_sync_ws (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in(ws_i),
    .pin_sync(ws_s)
  );

  ssap_sync u_sync_sdi (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in(sdi),
    .pin_sync(sdi_s)
  );

  // Edge finder needs at least four system cycles per half period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  assign fall_ev = (is_master && carry && sck_r) || (is_slave && sck_d_r && !sck_s);
  assign rise_ev = (is_master && carry && !sck_r) || (is_slave && !sck_d_r && sck_s);
  assign ws_line = is_master ? ws_r : ws_s;

  // ----------------------------------------------------------------------
  // Word framing
  // ----------------------------------------------------------------------
  // Word select is taken mid-bit so its own edge never races the clock edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ws_rise_r <= 1'b0;
      ws_fall_r <= 1'b0;
    end else if (role_r == ssap_pkg::ssap_role_off) begin
      // Fresh framing on each start, so no stale select change opens a word
      ws_rise_r <= 1'b0;
      ws_fall_r <= 1'b0;
    end else begin
      if (rise_ev) begin
        ws_rise_r <= ws_line;
      end
      if (fall_ev) begin
        ws_fall_r <= ws_rise_r;
      end
    end
  end

  // First falling edge after the select change starts a word
  assign word_start = fall_ev && (ws_rise_r != ws_fall_r);
  assign load_word = ws_rise_r ? right_hold_r : tx_left;

  // ----------------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      right_hold_r <= '0;
      tx_take_r <= 1'b0;
    end else begin
      tx_take_r <= 1'b0;
      // Both channels taken together so a frame is never torn
      if (word_start && !ws_rise_r && src_r) begin
        right_hold_r <= tx_right;
        tx_take_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_sh_r <= '0;
      sdo_r <= `SSAP_SDO_RST;
    end else if (role_r == ssap_pkg::ssap_role_off) begin
      tx_sh_r <= '0;
      sdo_r <= `SSAP_SDO_RST;
    end else if (word_start) begin
      // Sink role keeps the line low
      sdo_r <= src_r ? load_word[15] : 1'b0;
      tx_sh_r <= src_r ? {load_word[14:0], 1'b0} : '0;
    end else if (fall_ev) begin
      sdo_r <= tx_sh_r[15];
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Receive
  // ----------------------------------------------------------------------
  assign rx_sh_nxt = {rx_sh_r[14:0], sdi_s};

  // Select change seen at a rising edge closes the word just shifted in
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_sh_r <= '0;
      rx_left_hold_r <= '0;
      rx_left_r <= '0;
      rx_right_r <= '0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (rise_ev && !src_r) begin
        rx_sh_r <= rx_sh_nxt;
        if (ws_line != ws_rise_r) begin
          if (!ws_rise_r) begin
            rx_left_hold_r <= rx_sh_nxt;
          end else begin
            rx_left_r <= rx_left_hold_r;
            rx_right_r <= rx_sh_nxt;
            rx_valid_r <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign audio_grant = grant_r;
  assign tx_take = tx_take_r;
  assign rx_left = rx_left_r;
  assign rx_right = rx_right_r;
  assign rx_valid = rx_valid_r;
  assign sck_o = sck_r;
  assign sck_oe = sck_oe_r;
  assign ws_o = ws_r;
  assign ws_oe = ws_oe_r;
  assign sdo = sdo_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Cycles since the last divider overflow; a role drop restarts it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      half_cnt_r <= 4'h0;
    end else if (!is_master || carry) begin
      half_cnt_r <= 4'h0;
    end else if (half_cnt_r != 4'hF) begin
      half_cnt_r <= half_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_pin_dir: assert property (sck_oe_r == ws_oe_r && sck_oe_r == is_master)
    else $error("clock and select drive do not follow master role");

  a_sdo_edge: assert property (
    $changed(sdo_r) && $past(role_r != ssap_pkg::ssap_role_off) && role_r != ssap_pkg::ssap_role_off
    |-> $past(fall_ev))
    else $error("data out changed away from a falling edge");

  a_ws_period: assert property (
    $changed(ws_r) && is_master && $past(is_master) |-> $past(fall_ev && bit_cnt_r == 4'hF))
    else $error("word select toggled off the 16th falling edge");

  a_frame_len: assert property (
    $changed(ws_r) && is_master && $past(is_master) |-> bit_cnt_r == 4'h0)
    else $error("word did not span 16 bit periods");

  a_msb_launch: assert property (
    word_start && src_r && role_r != ssap_pkg::ssap_role_off |=> sdo_r == $past(load_word[15]))
    else $error("word MSB not launched after select change");

  a_sink_quiet: assert property (
    !src_r && $past(!src_r) && fall_ev |=> !sdo_r)
    else $error("data out driven while in sink role");

  a_pcm_excl: assert property (pcm_claim |=> !grant_r && !sck_oe_r)
    else $error("audio port kept hardware while voice claimed it");

  a_sck_rate: assert property (carry |-> half_cnt_r >= 4'h7 && half_cnt_r <= 4'h8)
    else $error("master bit clock half period out of range");

  a_rx_word: assert property (
    rx_valid_r |-> $past(rise_ev) && !$past(src_r) && $past(ws_rise_r))
    else $error("received pair closed outside a right word end");

endmodule : ssap_top

/* File: verif/ssap_codec.sv */
// Far-side codec model: slave clocking, word transmitter, word receiver
`timescale 1ns/1ns
module ssap_codec (
  // Control
  input wire logic run,
  input wire logic [15:0] word_l,
  input wire logic [15:0] word_r,
  // Lines
  input wire logic sck_line,
  input wire logic ws_line,
  input wire logic sdo,
  output logic sck_drv,
  output logic ws_drv,
  output logic sdi,
  // Captured words
  output logic [15:0] got_l,
  output logic [15:0] got_r
);
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic ws_tx;
  logic ws_rx;
  int i;

  // ----------------------------------------------------------------
  // Slave clocking, 320 ns period, no gap between frames while run stays high
  // ----------------------------------------------------------------
  initial begin
    sck_drv = 1'b0;
    ws_drv = 1'b0;
    forever begin
      wait (run);
      for (i = 0; i < 32 && run; i++) begin
        sck_drv = 1'b0;
        ws_drv = (i >= 15) && (i < 31);
        #160;
        sck_drv = 1'b1;
        #160;
      end
      if (!run) sck_drv = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit on falls, MSB one bit after select change
  // ----------------------------------------------------------------
  initial begin
    sdi = 1'b0;
    tx_sh = 16'h0000;
    ws_tx = 1'b0;
    ws_rx = 1'b0;
    rx_sh = 16'h0000;
    got_l = 16'h0000;
    got_r = 16'h0000;
  end
  always @(negedge sck_line) begin
    #1;
    sdi = tx_sh[15];
    tx_sh = {tx_sh[14:0], ~tx_sh[0]};
    if (ws_line !== ws_tx) begin
      ws_tx = ws_line;
      tx_sh = ws_line ? word_r : word_l;
    end
  end
  // Released line shows no stale level
  always @(negedge run) sdi = ~sdi;

  // ----------------------------------------------------------------
  // Receive on rises; select change closes the word
  // ----------------------------------------------------------------
  always @(posedge sck_line) begin
    rx_sh = {rx_sh[14:0], sdo};
    if (ws_line !== ws_rx) begin
      if (ws_rx) got_r = rx_sh;
      else got_l = rx_sh;
      ws_rx = ws_line;
    end
  end
endmodule : ssap_codec

/* File: verif/ssap_top_test.sv */
// Testbench of the stereo serial audio port against the codec model
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module ssap_top_test;
  typedef struct {logic m; logic r48; logic src; logic [15:0] l; logic [15:0] r;} ssap_row_s;
  logic clk_sys, resetn, cfg_enable, cfg_master, cfg_rate_48k, cfg_source, pcm_claim, run;
  ssap_pkg::ssap_word_t tx_left, tx_right, rx_left, rx_right, word_l, word_r, got_l, got_r;
  logic audio_grant, tx_take, rx_valid, sck_o, sck_oe, ws_o, ws_oe, sdo, sdi;
  logic sck_drv, ws_drv, sck_line, ws_line, prev_sdo, prev_sck, prev_ws;
  int errors, check_count, takes, valids, frame_len, frame_cnt, n;
  ssap_row_s rows [4] = '{'{1'b1, 1'b0, 1'b1, 16'hA55A, 16'h1234},
    '{1'b1, 1'b1, 1'b0, 16'h8001, 16'h7FFE}, '{1'b0, 1'b0, 1'b1, 16'hC3F0, 16'h0F3C},
    '{1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0001}};

  assign sck_line = sck_oe ? sck_o : sck_drv;
  assign ws_line = ws_oe ? ws_o : ws_drv;

  ssap_top ssap_top_inst (.clk_sys(clk_sys), .resetn(resetn), .cfg_enable(cfg_enable),
    .cfg_master(cfg_master), .cfg_rate_48k(cfg_rate_48k), .cfg_source(cfg_source),
    .pcm_claim(pcm_claim), .audio_grant(audio_grant), .tx_left(tx_left),
    .tx_right(tx_right), .tx_take(tx_take), .rx_left(rx_left), .rx_right(rx_right),
    .rx_valid(rx_valid), .sck_i(sck_line), .sck_o(sck_o), .sck_oe(sck_oe),
    .ws_i(ws_line), .ws_o(ws_o), .ws_oe(ws_oe), .sdo(sdo), .sdi(sdi));
  ssap_codec ssap_codec_inst (.run(run), .word_l(word_l), .word_r(word_r),
    .sck_line(sck_line), .ws_line(ws_line), .sdo(sdo), .sck_drv(sck_drv),
    .ws_drv(ws_drv), .sdi(sdi), .got_l(got_l), .got_r(got_r));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Monitor on falling edge, where outputs have settled
  // ----------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (tx_take === 1'b1) takes++;
    if (rx_valid === 1'b1) valids++;
    frame_cnt++;
    if (ws_oe === 1'b1 && ws_o === 1'b1 && prev_ws === 1'b0) begin
      frame_len = frame_cnt;
      frame_cnt = 0;
    end
    if (sck_oe === 1'b1 && sdo !== prev_sdo && !(prev_sck && !sck_line))
      `CHK(sdo, prev_sdo)
    prev_sdo = sdo;
    prev_sck = sck_line;
    prev_ws = ws_o;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Bounded wait for rising select edges
  task automatic wait_frames(input int f);
    int seen;
    int c;
    logic last;
    seen = 0;
    c = 0;
    last = ws_line;
    while (seen < f && c < 3000 * f) begin
      @(negedge clk_sys);
      c++;
      if (ws_line && !last) seen++;
      last = ws_line;
    end
    `CHK(seen, f)
  endtask : wait_frames

  task automatic run_row(input ssap_row_s w);
    int ex;
    cfg_enable = 1'b0;
    run = 1'b0;
    repeat (4) @(negedge clk_sys);
    {cfg_master, cfg_rate_48k, cfg_source} = {w.m, w.r48, w.src};
    {tx_left, tx_right, word_l, word_r} = {w.l, w.r, w.l, w.r};
    takes = 0;
    valids = 0;
    cfg_enable = 1'b1;
    run = !w.m;
    wait_frames(4);
    `CHK(audio_grant, 1'b1)
    `CHK(sck_oe, w.m)
    `CHK(ws_oe, w.m)
    if (w.src) begin
      `CHK(got_l, w.l)
      `CHK(got_r, w.r)
      `CHK(takes > 2, 1'b1)
    end else begin
      `CHK(rx_left, w.l)
      `CHK(rx_right, w.r)
      `CHK(valids > 2, 1'b1)
      `CHK(sdo, 1'b0)
      `CHK(takes, 0)
    end
    ex = w.r48 ? 521 : 567;
    if (w.m) `CHK(frame_len >= ex - 1 && frame_len <= ex + 1, 1'b1)
    $display("test done: master %0b rate48 %0b source %0b", w.m, w.r48, w.src);
  endtask : run_row

  initial begin
    #(40 * 60000);
    errors++;
    stop_test();
  end

  initial begin
    {resetn, cfg_enable, cfg_master, cfg_rate_48k, cfg_source, pcm_claim, run} = 7'h00;
    {tx_left, tx_right, word_l, word_r} = 64'h0;
    {errors, check_count, takes, valids, frame_len, frame_cnt} = '0;
    {prev_sdo, prev_sck, prev_ws} = 3'h0;
    repeat (2) @(negedge clk_sys);
    `CHK(audio_grant, 1'b0)
    resetn = 1'b1;
    foreach (rows[n]) run_row(rows[n]);
    // Voice claim takes the shared hardware away mid-stream
    run_row(rows[0]);
    pcm_claim = 1'b1;
    repeat (3) @(negedge clk_sys);
    takes = 0;
    `CHK({audio_grant, sck_oe, ws_oe, sdo}, 4'h0)
    repeat (1000) @(negedge clk_sys);
    `CHK(takes, 0)
    // New left sample proves the port really resumed after the claim
    tx_left = rows[1].l;
    pcm_claim = 1'b0;
    wait_frames(3);
    `CHK(got_l, rows[1].l)
    $display("test done: voice claim");
    // Reset in mid-frame clears every output at once
    resetn = 1'b0;
    #1;
    `CHK({audio_grant, sck_oe, ws_o, sdo, tx_take, rx_valid}, 6'h00)
    $display("test done: reset");
    stop_test();
  end
endmodule : ssap_top_test
